/* inc/sbc_pkg.sv */
// Constants shared by the processor sideband control block.
// Notes on behaviour
// - Address-20 mask asserts when fast gate port bit or gate input is active.
// - During bus reset, four strap-capable outputs show their frequency strap bits.
// - Processor sleep output may assert on S1 entry when software enables it.
// - With error reporting enabled, numeric error input raises interrupt line 13.
// - With error reporting enabled, numeric error clear write with error active asserts ignore numeric error.
// - Ignore numeric error stays asserted until numeric error input negates.
// - Numeric error clear write with error inactive leaves ignore deasserted.
// - Processor initialization pulse lasts at least 16 clock cycles; a new start during it reloads the count.
// - With self-test support enabled, initialization holds during bus reset.
// - Processor interrupt follows pending request, otherwise driven low.
// - Non-maskable interrupt rises on system error or channel check.
// - Setting a source disable bit clears that source's non-maskable interrupt.
// - System management interrupt is active low, clocked, from enabled events.
// - Stop clock request is active low, clocked, from hardware or software events.
// - Keyboard reset request assertion starts a 16-cycle initialization pulse.
// - Keyboard reset requests are ignored during S3, S4 or S5 transitions.
// - Processor power good is open-drain AND of core and regulator good.
`default_nettype none
package sbc_pkg;
  localparam int REG_AW = 8;
  localparam int REG_DW = 32;
  localparam logic [REG_AW-1:0] IO_FAST_GATE = 8'h92;
  localparam logic [REG_AW-1:0] IO_NUMERIC_ERR_CLR = 8'hf0;
  localparam logic [REG_AW-1:0] IO_NMI_CONTROL = 8'h6a;
  localparam logic [REG_AW-1:0] CFG_GENERAL_CONTROL = 8'hd0;
  localparam logic [REG_AW-1:0] CFG_FREQ_STRAP = 8'hd4;
  localparam logic [REG_AW-1:0] CFG_SIDEBAND_CONTROL = 8'hd8;
  localparam int FG_FAST_INIT_BIT = 0;
  localparam int FG_ADDR20_BIT = 1;
  localparam int GC_INIT_BIST_BIT = 1;
  localparam int GC_NUMERIC_ERR_EN_BIT = 13;
  localparam int STRAP_ADDR20_BIT = 0;
  localparam int STRAP_IGNORE_ERR_BIT = 1;
  localparam int STRAP_PROCESSOR_INTERRUPT_OUT_BIT = 2;
  localparam int STRAP_NMI_BIT = 3;
  localparam int SC_SMI_SW_BIT = 0;
  localparam int SC_SMI_HW_EN_BIT = 1;
  localparam int SC_STOP_CLK_SW_BIT = 2;
  localparam int SC_SLEEP_EN_BIT = 3;
  localparam int NC_SERR_DIS_BIT = 2;
  localparam int NC_IO_CHANNEL_CHECK_IN_DIS_BIT = 3;
  localparam int NC_IO_CHANNEL_CHECK_IN_STS_BIT = 6;
  localparam int NC_SERR_STS_BIT = 7;
  localparam logic [7:0] FAST_GATE_RST = 8'h00;
  localparam logic [31:0] GENERAL_CONTROL_RST = 32'h0000_0000;
  localparam logic [3:0] FREQ_STRAP_RST = 4'h0;
  localparam logic [3:0] SIDEBAND_CONTROL_RST = 4'h0;
  localparam logic [1:0] NMI_DISABLE_RST = 2'h0;
  localparam int INIT_PULSE_CYCLES = 16;
endpackage
`default_nettype wire

/* hw/sbc_pulse_timer.sv */
// Retriggerable fixed-length pulse timer.
`default_nettype none
module sbc_pulse_timer
  import sbc_pkg::*;
#(
  parameter int LEN = INIT_PULSE_CYCLES
)
(
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic start_in,
  output logic busy_out
);
  localparam int CW = $clog2(LEN + 1);
  localparam logic [CW-1:0] LOAD = CW'(LEN);

  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;

  if (LEN < 1)
  begin : g_bad_len
    $error("sbc_pulse_timer needs LEN of at least one");
  end

  // A start during a running pulse reloads the count, so pulses never overlap.
  assign count_nxt = start_in ? LOAD : ((count_r != '0) ? count_r - 1'b1 : count_r);
  assign busy_out = (count_r != '0);

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
      count_r <= '0;
    else
      count_r <= count_nxt;
  end
endmodule
`default_nettype wire

/* hw/sbc_nmi_source.sv */
// Sticky latch for one non-maskable interrupt source.
`default_nettype none
module sbc_nmi_source (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic source_in,
  input wire logic disable_in,
  input wire logic clear_in,
  output logic latch_out
);
  logic latch_r;
  logic latch_nxt;

  // A source event in the clearing cycle still sets the latch unless disabled.
  assign latch_nxt = (source_in & ~disable_in) | (latch_r & ~clear_in);
  assign latch_out = latch_r;

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
      latch_r <= 1'b0;
    else
      latch_r <= latch_nxt;
  end
endmodule
`default_nettype wire

/* hw/sbc_sideband_top.sv */
// Processor sideband control: mask, error handshake, init, interrupts, power good.
`default_nettype none
module sbc_sideband_top
  import sbc_pkg::*;
#(
  parameter int INIT_LEN = INIT_PULSE_CYCLES
)
(
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic reg_cfg_sel_in,
  input wire logic [REG_AW-1:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [REG_DW-1:0] reg_wdata_in,
  output logic [REG_DW-1:0] reg_rdata_out,
  input wire logic pci_bus_reset_in,
  input wire logic addr_bit20_gate_in,
  input wire logic numeric_error_n_in,
  input wire logic keyboard_reset_request_n_in,
  input wire logic io_channel_check_n_in,
  input wire logic pci_system_error_n_in,
  input wire logic irq_pending_in,
  input wire logic smi_event_in,
  input wire logic stop_clock_event_in,
  input wire logic s1_entry_in,
  input wire logic s345_transition_in,
  input wire logic core_power_ok_in,
  input wire logic regulator_power_good_in,
  output logic addr_bit20_mask_n_out,
  output logic processor_sleep_n_out,
  output logic ignore_numeric_error_n_out,
  output logic numeric_error_irq_out,
  output logic processor_init_n_out,
  output logic processor_interrupt_out,
  output logic non_maskable_interrupt_out,
  output logic system_mgmt_interrupt_n_out,
  output logic stop_clock_request_n_out,
  output logic processor_power_good_out,
  output logic processor_power_good_oe_out
);

  if (INIT_LEN < 1)
  begin : g_bad_init_len
    $error("sbc_sideband_top needs INIT_LEN of at least one");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  // Every register lives in exactly one space, so the select bit is part of each match.
  function automatic logic reg_hit(input logic cfg_sel, input logic [REG_AW-1:0] addr,
                                   input logic want_cfg, input logic [REG_AW-1:0] target);
    reg_hit = (cfg_sel == want_cfg) && (addr == target);
  endfunction

  logic hit_fast_gate;
  logic hit_err_clr;
  logic hit_nmi_ctl;
  logic hit_gen_ctl;
  logic hit_strap;
  logic hit_side_ctl;

  assign hit_fast_gate = reg_hit(reg_cfg_sel_in, reg_addr_in, 1'b0, IO_FAST_GATE);
  assign hit_err_clr = reg_hit(reg_cfg_sel_in, reg_addr_in, 1'b0, IO_NUMERIC_ERR_CLR);
  assign hit_nmi_ctl = reg_hit(reg_cfg_sel_in, reg_addr_in, 1'b0, IO_NMI_CONTROL);
  assign hit_gen_ctl = reg_hit(reg_cfg_sel_in, reg_addr_in, 1'b1, CFG_GENERAL_CONTROL);
  assign hit_strap = reg_hit(reg_cfg_sel_in, reg_addr_in, 1'b1, CFG_FREQ_STRAP);
  assign hit_side_ctl = reg_hit(reg_cfg_sel_in, reg_addr_in, 1'b1, CFG_SIDEBAND_CONTROL);

  logic wr_fast_gate;
  logic wr_err_clr;
  logic wr_nmi_ctl;
  logic wr_gen_ctl;
  logic wr_strap;
  logic wr_side_ctl;

  assign wr_fast_gate = reg_wr_in & hit_fast_gate;
  assign wr_err_clr = reg_wr_in & hit_err_clr;
  assign wr_nmi_ctl = reg_wr_in & hit_nmi_ctl;
  assign wr_gen_ctl = reg_wr_in & hit_gen_ctl;
  assign wr_strap = reg_wr_in & hit_strap;
  assign wr_side_ctl = reg_wr_in & hit_side_ctl;

  ////////////////////////////////////////////////////////////////////////////
  // Software registers.

  // Only the implemented low bits of the fast gate, strap and sideband registers are kept; the rest read as zero.
  logic [7:0] fast_gate_port_r;
  logic [31:0] general_control_r;
  logic [3:0] frequency_strap_register_r;
  logic [3:0] sideband_control_r;
  logic [1:0] nmi_disable_r;

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      fast_gate_port_r <= FAST_GATE_RST;
      general_control_r <= GENERAL_CONTROL_RST;
      frequency_strap_register_r <= FREQ_STRAP_RST;
      sideband_control_r <= SIDEBAND_CONTROL_RST;
      nmi_disable_r <= NMI_DISABLE_RST;
    end
    else
    begin
      if (wr_fast_gate)
        fast_gate_port_r <= reg_wdata_in[7:0];
      if (wr_gen_ctl)
        general_control_r <= reg_wdata_in;
      if (wr_strap)
        frequency_strap_register_r <= reg_wdata_in[3:0];
      if (wr_side_ctl)
        sideband_control_r <= reg_wdata_in[3:0];
      if (wr_nmi_ctl)
        nmi_disable_r <= {reg_wdata_in[NC_IO_CHANNEL_CHECK_IN_DIS_BIT], reg_wdata_in[NC_SERR_DIS_BIT]};
    end
  end

  logic err_report_en;
  logic bist_en;
  logic strap_phase;

  assign err_report_en = general_control_r[GC_NUMERIC_ERR_EN_BIT];
  assign bist_en = general_control_r[GC_INIT_BIST_BIT];
  // The strap register survives bus reset so its values can be shown during it.
  assign strap_phase = pci_bus_reset_in;

  ////////////////////////////////////////////////////////////////////////////
  // Numeric error handshake.

  logic numeric_error;
  logic ignore_err_r;
  logic ignore_err_nxt;

  assign numeric_error = ~numeric_error_n_in;
  // Set only when the error is live at the write; drop once the error negates.
  assign ignore_err_nxt = (wr_err_clr & err_report_en & numeric_error)
                        | (ignore_err_r & numeric_error);

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
      ignore_err_r <= 1'b0;
    else
      ignore_err_r <= ignore_err_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Processor initialization.

  logic kbd_req_prev_r;
  logic kbd_start;
  logic fast_init_start;
  logic init_start;
  logic init_busy;

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
      kbd_req_prev_r <= 1'b0;
    else
      kbd_req_prev_r <= ~keyboard_reset_request_n_in;
  end

  // Only a fresh high-to-low request starts a pulse, so a held request never retriggers.
  assign kbd_start = ~keyboard_reset_request_n_in & ~kbd_req_prev_r
                   & ~s345_transition_in;
  assign fast_init_start = wr_fast_gate & reg_wdata_in[FG_FAST_INIT_BIT]
                         & ~fast_gate_port_r[FG_FAST_INIT_BIT];
  assign init_start = kbd_start | fast_init_start;

  sbc_pulse_timer #(
    .LEN(INIT_LEN)
  ) u_init_timer (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .start_in(init_start),
    .busy_out(init_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Non-maskable interrupt sources.

  logic serr_latch;
  logic io_channel_check_in_latch;
  logic serr_clear;
  logic io_channel_check_in_clear;

  // Writing a one to a disable bit retires that source's pending interrupt.
  assign serr_clear = wr_nmi_ctl & reg_wdata_in[NC_SERR_DIS_BIT];
  assign io_channel_check_in_clear = wr_nmi_ctl & reg_wdata_in[NC_IO_CHANNEL_CHECK_IN_DIS_BIT];

  logic serr_block;
  logic io_channel_check_in_block;

  // The disabling write blocks its source in the same cycle; otherwise a source
  // that is still active would re-arm the latch and the interrupt would never drop.
  assign serr_block = nmi_disable_r[0] | serr_clear;
  assign io_channel_check_in_block = nmi_disable_r[1] | io_channel_check_in_clear;

  sbc_nmi_source u_serr_src (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .source_in(~pci_system_error_n_in),
    .disable_in(serr_block),
    .clear_in(serr_clear),
    .latch_out(serr_latch)
  );

  sbc_nmi_source u_io_channel_check_in_src (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .source_in(~io_channel_check_n_in),
    .disable_in(io_channel_check_in_block),
    .clear_in(io_channel_check_in_clear),
    .latch_out(io_channel_check_in_latch)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output level selection.

  logic a20_mask_n_nxt;
  logic ignore_n_nxt;
  logic processor_interrupt_out_nxt;
  logic nmi_nxt;
  logic init_n_nxt;
  logic sleep_n_nxt;
  logic smi_n_nxt;
  logic stop_n_nxt;
  logic numeric_error_irq_line_nxt;
  logic pg_oe_nxt;

  assign a20_mask_n_nxt = strap_phase ? frequency_strap_register_r[STRAP_ADDR20_BIT]
    : ~(fast_gate_port_r[FG_ADDR20_BIT] | addr_bit20_gate_in);
  assign ignore_n_nxt = strap_phase ? frequency_strap_register_r[STRAP_IGNORE_ERR_BIT]
    : ~ignore_err_r;
  assign processor_interrupt_out_nxt = strap_phase ? frequency_strap_register_r[STRAP_PROCESSOR_INTERRUPT_OUT_BIT]
    : irq_pending_in;
  // A rising edge is what the processor acts on, so a held level raises one event.
  assign nmi_nxt = strap_phase ? frequency_strap_register_r[STRAP_NMI_BIT]
    : (serr_latch | io_channel_check_in_latch);
  // Self-test support turns bus reset into a held init that overrides the pulse timer.
  assign init_n_nxt = ~(init_busy | (bist_en & pci_bus_reset_in));
  assign sleep_n_nxt = ~(s1_entry_in & sideband_control_r[SC_SLEEP_EN_BIT]);
  assign smi_n_nxt = ~(sideband_control_r[SC_SMI_SW_BIT]
    | (smi_event_in & sideband_control_r[SC_SMI_HW_EN_BIT]));
  assign stop_n_nxt = ~(sideband_control_r[SC_STOP_CLK_SW_BIT] | stop_clock_event_in);
  assign numeric_error_irq_line_nxt = err_report_en & numeric_error;
  // Open drain: pull low unless both power monitors report good.
  assign pg_oe_nxt = ~(core_power_ok_in & regulator_power_good_in);

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs.

  logic [REG_DW-1:0] rdata_nxt;
  logic [7:0] nmi_ctl_view;

  // Read data lags the address by one cycle; write-only and unmapped offsets read zero.
  assign nmi_ctl_view = {serr_latch, io_channel_check_in_latch, 2'b00, nmi_disable_r[1], nmi_disable_r[0],
                         2'b00};
  assign rdata_nxt = hit_fast_gate ? {24'h00_0000, fast_gate_port_r}
                   : hit_gen_ctl ? general_control_r
                   : hit_strap ? {28'h000_0000, frequency_strap_register_r}
                   : hit_side_ctl ? {28'h000_0000, sideband_control_r}
                   : hit_nmi_ctl ? {24'h00_0000, nmi_ctl_view}
                   : 32'h0000_0000;

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      reg_rdata_out <= 32'h0000_0000;
      addr_bit20_mask_n_out <= 1'b1;
      processor_sleep_n_out <= 1'b1;
      ignore_numeric_error_n_out <= 1'b1;
      numeric_error_irq_out <= 1'b0;
      processor_init_n_out <= 1'b1;
      processor_interrupt_out <= 1'b0;
      non_maskable_interrupt_out <= 1'b0;
      system_mgmt_interrupt_n_out <= 1'b1;
      stop_clock_request_n_out <= 1'b1;
      processor_power_good_out <= 1'b0;
      processor_power_good_oe_out <= 1'b1;
    end
    else
    begin
      reg_rdata_out <= rdata_nxt;
      addr_bit20_mask_n_out <= a20_mask_n_nxt;
      processor_sleep_n_out <= sleep_n_nxt;
      ignore_numeric_error_n_out <= ignore_n_nxt;
      numeric_error_irq_out <= numeric_error_irq_line_nxt;
      processor_init_n_out <= init_n_nxt;
      processor_interrupt_out <= processor_interrupt_out_nxt;
      non_maskable_interrupt_out <= nmi_nxt;
      system_mgmt_interrupt_n_out <= smi_n_nxt;
      stop_clock_request_n_out <= stop_n_nxt;
      // The pin value stays low; only the enable moves and the pull-up gives the high.
      processor_power_good_out <= 1'b0;
      processor_power_good_oe_out <= pg_oe_nxt;
    end
  end
endmodule
`default_nettype wire

/* sim/sbc_host_model.sv */
// Behavioural host processor and keyboard controller facing the sideband block.
`default_nettype none
module sbc_host_model #(
  parameter int PWR_DELAY = 8
)
(
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic kbd_req_in,
  input wire logic gate_req_in,
  input wire logic fpu_err_in,
  input wire logic power_stable_in,
  input wire logic nmi_in,
  input wire logic stop_clock_n_in,
  output logic kbd_reset_n_out,
  output logic gate_out,
  output logic fpu_err_n_out,
  output logic core_ok_out,
  output logic [7:0] nmi_count_out,
  output logic clock_stopped_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] stable_cnt_r;
  logic nmi_prev_r;
  assign kbd_reset_n_out = !kbd_req_in;
  assign gate_out = gate_req_in;
  assign fpu_err_n_out = !fpu_err_in;
  // Power ok waits out a settling span, so the block never sees it early.
  assign core_ok_out = (stable_cnt_r == 8'(PWR_DELAY));
  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_in or posedge reset_in)
    if (reset_in)
    begin
      stable_cnt_r <= 8'h00;
      nmi_prev_r <= 1'b0;
      nmi_count_out <= 8'h00;
      clock_stopped_out <= 1'b0;
    end
    else
    begin
      stable_cnt_r <= !power_stable_in ? 8'h00 : core_ok_out ? stable_cnt_r : stable_cnt_r + 8'h01;
      nmi_prev_r <= nmi_in;
      // A level held high is one interrupt only, so just edges are counted.
      if (nmi_in && !nmi_prev_r)
        nmi_count_out <= nmi_count_out + 8'h01;
      clock_stopped_out <= !stop_clock_n_in;
    end
endmodule
`default_nettype wire

/* sim/sbc_sideband_sva.sv */
// Concurrent checks on the ports of the sideband control block.
`default_nettype none
module sbc_sideband_sva #(
  parameter int INIT_LEN = 16
)
(
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic pci_bus_reset_in,
  input wire logic addr_bit20_gate_in,
  input wire logic numeric_error_n_in,
  input wire logic keyboard_reset_request_n_in,
  input wire logic io_channel_check_n_in,
  input wire logic pci_system_error_n_in,
  input wire logic irq_pending_in,
  input wire logic stop_clock_event_in,
  input wire logic s345_transition_in,
  input wire logic core_power_ok_in,
  input wire logic regulator_power_good_in,
  input wire logic addr_bit20_mask_n_out,
  input wire logic ignore_numeric_error_n_out,
  input wire logic processor_init_n_out,
  input wire logic processor_interrupt_out,
  input wire logic non_maskable_interrupt_out,
  input wire logic stop_clock_request_n_out,
  input wire logic processor_power_good_oe_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  // Counts low samples of init; a hold from bus reset is flagged, as it may run any length.
  logic [7:0] low_cnt_r;
  logic hold_seen_r;
  always_ff @(posedge ref_clk_in or posedge reset_in)
    if (reset_in)
    begin
      low_cnt_r <= 8'h00;
      hold_seen_r <= 1'b0;
    end
    else if (processor_init_n_out)
    begin
      low_cnt_r <= 8'h00;
      hold_seen_r <= 1'b0;
    end
    else
    begin
      low_cnt_r <= low_cnt_r + 8'h01;
      hold_seen_r <= hold_seen_r | pci_bus_reset_in;
    end
  //////////////////////////////////////////////////////////////////////////////
  property p_mask;
    (addr_bit20_gate_in && !pci_bus_reset_in) |=> !addr_bit20_mask_n_out;
  endproperty
  a_mask: assert property (p_mask) else $error("mask missing after gate");
  property p_processor_interrupt_out;
    !pci_bus_reset_in |=> processor_interrupt_out == $past(irq_pending_in);
  endproperty
  a_processor_interrupt_out: assert property (p_processor_interrupt_out) else $error("interrupt not following pending");
  property p_ign_hold;
    (!ignore_numeric_error_n_out && !$past(numeric_error_n_in) && !$past(pci_bus_reset_in)
      && !pci_bus_reset_in) |=> !ignore_numeric_error_n_out;
  endproperty
  a_ign_hold: assert property (p_ign_hold) else $error("ignore released early");
  property p_ign_fall;
    $fell(ignore_numeric_error_n_out) |-> $past(pci_bus_reset_in) || !$past(numeric_error_n_in, 2);
  endproperty
  a_ign_fall: assert property (p_ign_fall) else $error("ignore without error");
  property p_init_len;
    ($rose(processor_init_n_out) && !hold_seen_r) |-> low_cnt_r >= INIT_LEN;
  endproperty
  a_init_len: assert property (p_init_len) else $error("init pulse too short");
  property p_kbd_start;
    ($fell(keyboard_reset_request_n_in) && !s345_transition_in) |-> ##2 !processor_init_n_out;
  endproperty
  a_kbd_start: assert property (p_kbd_start) else $error("no init after request");
  property p_nmi;
    ((!pci_system_error_n_in || !io_channel_check_n_in) && !pci_bus_reset_in) ##1
      !pci_bus_reset_in |=> non_maskable_interrupt_out;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi missing after source");
  property p_stop;
    stop_clock_event_in |=> !stop_clock_request_n_out;
  endproperty
  a_stop: assert property (p_stop) else $error("stop clock missing");
  property p_pgood;
    1'b1 |=> processor_power_good_oe_out == !$past(core_power_ok_in && regulator_power_good_in);
  endproperty
  a_pgood: assert property (p_pgood) else $error("power good not the and");
endmodule
bind sbc_sideband_top sbc_sideband_sva #(.INIT_LEN(INIT_LEN)) sbc_sideband_sva_inst (.*);
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the processor sideband control block.
`default_nettype none
module testbench
  import sbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_in, reset_in, reg_cfg_sel_in, reg_wr_in, pci_bus_reset_in, addr_bit20_gate_in;
  logic numeric_error_n_in, keyboard_reset_request_n_in, io_channel_check_n_in;
  logic pci_system_error_n_in, irq_pending_in, smi_event_in, stop_clock_event_in;
  logic s1_entry_in, s345_transition_in, core_power_ok_in, regulator_power_good_in;
  logic [REG_AW-1:0] reg_addr_in;
  logic [REG_DW-1:0] reg_wdata_in, reg_rdata_out;
  logic addr_bit20_mask_n_out, processor_sleep_n_out, ignore_numeric_error_n_out;
  logic numeric_error_irq_out, processor_init_n_out, processor_interrupt_out;
  logic non_maskable_interrupt_out, system_mgmt_interrupt_n_out, stop_clock_request_n_out;
  logic processor_power_good_out, processor_power_good_oe_out;
  logic kbd_req, gate_req, fpu_err, power_stable, clock_stopped;
  logic [7:0] nmi_count;
  int err_total, check_count, n;
  sbc_sideband_top #(.INIT_LEN(16)) sbc_sideband_top_inst (.*);
  sbc_host_model #(.PWR_DELAY(8)) sbc_host_model_inst (.ref_clk_in(ref_clk_in),
    .reset_in(reset_in), .kbd_req_in(kbd_req), .gate_req_in(gate_req), .fpu_err_in(fpu_err),
    .power_stable_in(power_stable), .nmi_in(non_maskable_interrupt_out),
    .stop_clock_n_in(stop_clock_request_n_out), .kbd_reset_n_out(keyboard_reset_request_n_in),
    .gate_out(addr_bit20_gate_in), .fpu_err_n_out(numeric_error_n_in),
    .core_ok_out(core_power_ok_in), .nmi_count_out(nmi_count),
    .clock_stopped_out(clock_stopped));
  //////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk_in);
  endtask
  task automatic wr(input logic c, input logic [7:0] a, input logic [31:0] d);
    reg_cfg_sel_in = c;
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    cyc(1);
    reg_wr_in = 1'b0;
    // The idle cycle keeps a following write from raising the strobe in the same step.
    cyc(1);
  endtask
  task automatic rd(input logic c, input logic [7:0] a, input logic [31:0] e);
    reg_cfg_sel_in = c;
    reg_addr_in = a;
    cyc(1);
    chk("rdata", e, reg_rdata_out);
  endtask
  // Counts init low cycles; the bounds keep a stuck pin from hanging the run.
  task automatic low_run(output int k);
    int w;
    k = 0;
    w = 0;
    while (processor_init_n_out !== 1'b0 && w < 8)
    begin
      cyc(1);
      w++;
    end
    while (processor_init_n_out === 1'b0 && k < 60)
    begin
      cyc(1);
      k++;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  initial
  begin
    #100000;
    err_total++;
    end_of_test();
  end
  initial
  begin
    reset_in = 1'b1;
    {reg_cfg_sel_in, reg_wr_in, pci_bus_reset_in, kbd_req, gate_req, fpu_err} = '0;
    {irq_pending_in, smi_event_in, stop_clock_event_in, s1_entry_in, s345_transition_in} = '0;
    {io_channel_check_n_in, pci_system_error_n_in, power_stable, regulator_power_good_in} = '1;
    reg_addr_in = 8'h00;
    reg_wdata_in = 32'h0000_0000;
    cyc(4);
    reset_in = 1'b0;
    cyc(12);
    wr(1'b0, 8'hf0, 32'h0000_00ff);
    wr(1'b0, 8'h10, 32'hffff_ffff);
    rd(1'b0, 8'hf0, 32'h0000_0000);
    rd(1'b0, 8'h10, 32'h0000_0000);
    rd(1'b1, 8'hd0, 32'h0000_0000);
    rd(1'b0, 8'h92, 32'h0000_0000);
    gate_req = 1'b1;
    cyc(2);
    chk("mask_gate", 0, addr_bit20_mask_n_out);
    gate_req = 1'b0;
    wr(1'b0, 8'h92, 32'h0000_0002);
    cyc(2);
    chk("mask_port", 0, addr_bit20_mask_n_out);
    rd(1'b0, 8'h92, 32'h0000_0002);
    kbd_req = 1'b1;
    low_run(n);
    chk("init_kbd", 16, n);
    kbd_req = 1'b0;
    wr(1'b0, 8'h92, 32'h0000_0001);
    low_run(n);
    chk("init_port", 16, n);
    wr(1'b0, 8'h92, 32'h0000_0000);
    wr(1'b0, 8'h92, 32'h0000_0001);
    cyc(6);
    kbd_req = 1'b1;
    low_run(n);
    chk("init_restart", 18, n);
    kbd_req = 1'b0;
    s345_transition_in = 1'b1;
    cyc(1);
    kbd_req = 1'b1;
    cyc(20);
    chk("init_s345", 1, processor_init_n_out);
    {kbd_req, s345_transition_in} = '0;
    wr(1'b1, 8'hd0, 32'h0000_2000);
    fpu_err = 1'b1;
    cyc(2);
    chk("numeric_error_irq_line", 1, numeric_error_irq_out);
    wr(1'b0, 8'hf0, 32'h0000_0000);
    cyc(2);
    chk("ignore_set", 0, ignore_numeric_error_n_out);
    cyc(6);
    chk("ignore_hold", 0, ignore_numeric_error_n_out);
    fpu_err = 1'b0;
    cyc(3);
    chk("ignore_free", 1, ignore_numeric_error_n_out);
    wr(1'b0, 8'hf0, 32'h0000_0000);
    cyc(3);
    chk("ignore_idle", 1, ignore_numeric_error_n_out);
    wr(1'b1, 8'hd0, 32'h0000_0000);
    fpu_err = 1'b1;
    cyc(2);
    chk("numeric_error_irq_line_off", 0, numeric_error_irq_out);
    fpu_err = 1'b0;
    irq_pending_in = 1'b1;
    cyc(2);
    chk("processor_interrupt_out", 1, processor_interrupt_out);
    irq_pending_in = 1'b0;
    cyc(2);
    chk("processor_interrupt_out_low", 0, processor_interrupt_out);
    for (int i = 0; i < 2; i++)
    begin
      {io_channel_check_n_in, pci_system_error_n_in} = i ? 2'b01 : 2'b10;
      cyc(3);
      chk("nmi_set", 1, non_maskable_interrupt_out);
      chk("nmi_edges", i + 1, nmi_count);
      {io_channel_check_n_in, pci_system_error_n_in} = 2'b11;
      wr(1'b0, 8'h6a, i ? 32'h0000_0004 : 32'h0000_0008);
      cyc(2);
      chk("nmi_kept", 1, non_maskable_interrupt_out);
      wr(1'b0, 8'h6a, i ? 32'h0000_0008 : 32'h0000_0004);
      cyc(2);
      chk("nmi_clear", 0, non_maskable_interrupt_out);
      wr(1'b0, 8'h6a, 32'h0000_0000);
    end
    smi_event_in = 1'b1;
    cyc(2);
    chk("smi_masked", 1, system_mgmt_interrupt_n_out);
    wr(1'b1, 8'hd8, 32'h0000_0002);
    cyc(2);
    chk("smi_hw", 0, system_mgmt_interrupt_n_out);
    smi_event_in = 1'b0;
    wr(1'b1, 8'hd8, 32'h0000_0001);
    cyc(2);
    chk("smi_sw", 0, system_mgmt_interrupt_n_out);
    stop_clock_event_in = 1'b1;
    cyc(2);
    chk("stop_hw", 0, stop_clock_request_n_out);
    chk("cpu_stopped", 1, clock_stopped);
    stop_clock_event_in = 1'b0;
    wr(1'b1, 8'hd8, 32'h0000_0004);
    cyc(2);
    chk("stop_sw", 0, stop_clock_request_n_out);
    wr(1'b1, 8'hd8, 32'h0000_0008);
    s1_entry_in = 1'b1;
    cyc(2);
    chk("sleep", 0, processor_sleep_n_out);
    chk("smi_idle", 1, system_mgmt_interrupt_n_out);
    s1_entry_in = 1'b0;
    wr(1'b1, 8'hd0, 32'h0000_0002);
    for (int s = 5; s < 11; s += 5)
    begin
      wr(1'b1, 8'hd4, 32'(s));
      pci_bus_reset_in = 1'b1;
      cyc(2);
      chk("strap", s, {non_maskable_interrupt_out, processor_interrupt_out,
        ignore_numeric_error_n_out, addr_bit20_mask_n_out});
      chk("init_hold", 0, processor_init_n_out);
      pci_bus_reset_in = 1'b0;
      cyc(24);
    end
    for (int i = 0; i < 4; i++)
    begin
      {regulator_power_good_in, power_stable} = 2'(i);
      cyc(12);
      chk("pgood_oe", i != 3, processor_power_good_oe_out);
      chk("pgood", 0, processor_power_good_out);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
